// [logic/alm_top.sv]
// alarm limits, panel menu, offset/slope trim and min/max memory
//
// Operation
// - button 1 cycles upper, lower, delay; 4 exits
// - value above upper or below lower alarms
// - alarm delay held and counted in seconds
// - alarm only after condition held for delay
// - alarm outputs inverted, active when no alarm
// - button 1 in edit commits, back to view
// - button 2 or 3 in view starts edit
// - step by one; repeat after 1 s, faster later
// - stepping wraps between range ends
// - button 4 cancels edit or closes menu
// - 10 s idle in edit discards edit
// - 60 s idle in menu closes menu
// - mode change clears offset and slope
// - rear plus button 3 over 2 s opens trim
// - button 1 toggles offset and slope; 4 exits
// - temperature: (value - offset) times slope factor
// - standard signal: slope around the low scale point
// - slope signed hundredths of a percent, offset in digits
// - track highest and lowest displayed values
// - short button 3 shows low tag then minimum
// - short button 2 shows high tag then maximum
// - buttons 2 and 3 for 2 s clear extremes
// - system error raises both alarms
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module alm_top
  import alm_pkg::*;
#(
  parameter int FAST_CYC_P = FAST_CYC
) (
  // clock, reset, enable
  input  wire logic               I_CLK,
  input  wire logic               I_RESET_N,
  input  wire logic               I_CE,
  // wishbone slave
  input  wire logic               I_WB_CYC,
  input  wire logic               I_WB_STB,
  input  wire logic               I_WB_WE,
  input  wire logic [7:0]         I_WB_ADR,
  input  wire logic [3:0]         I_WB_SEL,
  input  wire logic [31:0]        I_WB_DAT,
  output wire logic [31:0]        O_WB_DAT,
  output wire logic               O_WB_ACK,
  // panel buttons and power-on state
  input  wire logic [4:0]         I_BTN,
  input  wire logic               I_SEG_TEST_DONE,
  // measured value source
  input  wire logic signed [15:0] I_MEAS,
  input  wire logic               I_SYS_ERR,
  // display and alarm outputs
  output wire logic [15:0]        O_DISP_VAL,
  output wire logic [3:0]         O_DISP_TAG,
  output wire logic               O_HI_ALARM_N,
  output wire logic               O_LO_ALARM_N
);

  // step with wrap-around between range ends
  function automatic logic signed [15:0] step_wrap(
    input logic signed [15:0] v,
    input logic               up,
    input logic signed [15:0] lo
  );
    if (up) begin
      step_wrap = (v >= VAL_MAX) ? lo : v + 16'sh0001;
    end else begin
      step_wrap = (v <= lo) ? VAL_MAX : v - 16'sh0001;
    end
  endfunction : step_wrap

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] wmerge(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    wmerge = old;
    if (sel[0]) wmerge[7:0] = dat[7:0];
    if (sel[1]) wmerge[15:8] = dat[15:8];
  endfunction : wmerge

  // button synchroniser and hold timing
  logic [4:0]  btn_m_q, btn_s_q, btn_p_q;
  logic [23:0] fdiv_q, fdiv_d;
  logic [2:0]  sub_q, sub_d;
  logic [4:0]  hold_q, hold_d;
  logic [6:0]  idle_q, idle_d;
  logic [4:0]  press;
  logic        ftick, stick;

  assign press = btn_s_q & ~btn_p_q;
  assign ftick = (fdiv_q == 24'(FAST_CYC_P - 1));
  assign stick = ftick && (sub_q == 3'h7);

  // tick dividers, hold and idle counters
  always_comb begin
    fdiv_d = ftick ? 24'h000000 : fdiv_q + 24'h000001;
    sub_d  = ftick ? sub_q + 3'h1 : sub_q;
    hold_d = hold_q;
    if (btn_s_q != btn_p_q) begin
      hold_d = 5'h00;
    end else if (ftick && btn_s_q != 5'h00 && hold_q != 5'h1F) begin
      hold_d = hold_q + 5'h01;
    end
    idle_d = idle_q;
    if (press != 5'h00) begin
      idle_d = 7'h00;
    end else if (stick && idle_q != 7'h7F) begin
      idle_d = idle_q + 7'h01;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      btn_m_q <= 5'h00;
      btn_s_q <= 5'h00;
      btn_p_q <= 5'h00;
      fdiv_q  <= 24'h000000;
      sub_q   <= 3'h0;
      hold_q  <= 5'h00;
      idle_q  <= 7'h00;
    end else if (I_CE) begin
      btn_m_q <= I_BTN;
      btn_s_q <= btn_m_q;
      btn_p_q <= btn_s_q;
      fdiv_q  <= fdiv_d;
      sub_q   <= sub_d;
      hold_q  <= hold_d;
      idle_q  <= idle_d;
    end
  end

  // menu, parameters and extremes
  alm_st_t            st_q, st_d;
  logic [1:0]         item_q, item_d;
  logic               rhi_q, rhi_d;
  logic [4:0]         show_q, show_d;
  logic signed [15:0] edit_q, edit_d, upper_q, upper_d, lower_q, lower_d;
  logic signed [15:0] delay_q, delay_d, offset_q, offset_d;
  logic signed [15:0] slope_q, slope_d, scalo_q, scalo_d;
  logic signed [15:0] min_q, min_d, max_q, max_d, disp_q;
  logic [4:0]         ctrl_q, ctrl_d;
  logic [15:0]        oval_q, oval_d;
  alm_tag_t           tag_q, tag_d;
  logic               trm, rep, s_up, s_dn, wr, mode_chg, clr;
  logic signed [15:0] cur, lo_end;

  assign wr = I_WB_CYC && I_WB_STB && O_WB_ACK == 1'b0 && I_WB_WE;
  assign mode_chg = wr && I_WB_ADR == REG_CTRL && I_WB_SEL[0]
                    && I_WB_DAT[3:0] != ctrl_q[3:0];
  assign trm = (st_q == S_TRM_VIEW) || (st_q == S_TRM_EDIT);
  assign rep = ftick && hold_q >= REPEAT_F
               && (hold_q >= FASTR_F || !hold_q[0]);
  assign s_up = press[1] || (btn_s_q == BTN_UP && rep);
  assign s_dn = press[2] || (btn_s_q == BTN_DOWN && rep);
  assign clr = st_q == S_IDLE && btn_s_q == BTN_CLR && ftick
               && hold_q == COMBO_F - 5'h01;
  assign cur = trm ? (item_q[0] ? slope_q : offset_q)
             : (item_q == 2'h0 ? upper_q
             : (item_q == 2'h1 ? lower_q : delay_q));
  assign lo_end = (!trm && item_q == 2'h2) ? DLY_MIN : VAL_MIN;

  always_comb begin
    st_d = st_q;
    item_d = item_q;
    rhi_d = rhi_q;
    show_d = ftick ? show_q + 5'h01 : show_q;
    edit_d = edit_q;
    upper_d = upper_q;
    lower_d = lower_q;
    delay_d = delay_q;
    offset_d = offset_q;
    slope_d = slope_q;
    scalo_d = scalo_q;
    ctrl_d = ctrl_q;
    // software writes
    if (wr) begin
      case (I_WB_ADR)
        REG_CTRL:   if (I_WB_SEL[0]) ctrl_d = I_WB_DAT[4:0];
        REG_SCALO:  scalo_d = wmerge(scalo_q, I_WB_DAT, I_WB_SEL);
        REG_UPPER:  upper_d = wmerge(upper_q, I_WB_DAT, I_WB_SEL);
        REG_LOWER:  lower_d = wmerge(lower_q, I_WB_DAT, I_WB_SEL);
        REG_DELAY:  delay_d = wmerge(delay_q, I_WB_DAT, I_WB_SEL);
        REG_OFFSET: offset_d = wmerge(offset_q, I_WB_DAT, I_WB_SEL);
        REG_SLOPE:  slope_d = wmerge(slope_q, I_WB_DAT, I_WB_SEL);
        default:    ctrl_d = ctrl_q;
      endcase
    end
    // panel state machine
    case (st_q)
      S_IDLE: begin
        if (press == BTN_NEXT && btn_s_q == BTN_NEXT) begin
          st_d = S_ALM_VIEW;
          item_d = 2'h0;
        end else if (btn_s_q == BTN_TRIM && ftick && hold_q == COMBO_F
                     && I_SEG_TEST_DONE) begin
          st_d = S_TRM_VIEW;
          item_d = 2'h0;
        end else if (clr) begin
          st_d = S_CLR_TAG;
          show_d = 5'h00;
        end else if (btn_s_q == 5'h00 && hold_q < REPEAT_F
                     && (btn_p_q == BTN_UP || btn_p_q == BTN_DOWN)) begin
          st_d = S_REC_TAG;
          rhi_d = (btn_p_q == BTN_UP);
          show_d = 5'h00;
        end
      end
      S_ALM_VIEW, S_TRM_VIEW: begin
        if (idle_q > TMO_MENU_S || press[3]) begin
          st_d = S_IDLE;
        end else if (press[0]) begin
          if (trm) begin
            item_d = {1'b0, ~item_q[0]};
          end else begin
            item_d = (item_q == 2'h2) ? 2'h0 : item_q + 2'h1;
          end
        end else if (press[1] || press[2]) begin
          st_d = trm ? S_TRM_EDIT : S_ALM_EDIT;
          edit_d = cur;
        end
      end
      S_ALM_EDIT, S_TRM_EDIT: begin
        if (press[3] || idle_q > TMO_EDIT_S) begin
          st_d = trm ? S_TRM_VIEW : S_ALM_VIEW;
        end else if (press[0]) begin
          st_d = trm ? S_TRM_VIEW : S_ALM_VIEW;
          case ({trm, item_q})
            3'b000:  upper_d = edit_q;
            3'b001:  lower_d = edit_q;
            3'b010:  delay_d = edit_q;
            3'b100:  offset_d = edit_q;
            default: slope_d = edit_q;
          endcase
        end else if (s_up || s_dn) begin
          edit_d = step_wrap(edit_q, s_up, lo_end);
        end
      end
      S_REC_TAG: begin
        if (ftick && show_q == TAG_F - 5'h01) begin
          st_d = S_REC_VAL;
          show_d = 5'h00;
        end
      end
      S_REC_VAL, S_CLR_TAG: begin
        if (ftick && show_q == ((st_q == S_CLR_TAG) ? TAG_F : SHOW_F)
            - 5'h01) begin
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (mode_chg) begin
      offset_d = 16'sh0000;
      slope_d = 16'sh0000;
    end
    // extremes memory
    min_d = (disp_q < min_q) ? disp_q : min_q;
    max_d = (disp_q > max_q) ? disp_q : max_q;
    if (clr) begin
      min_d = disp_q;
      max_d = disp_q;
    end
    // display content
    tag_d = T_VALUE;
    oval_d = disp_q;
    case (st_q)
      S_ALM_VIEW: tag_d = alm_tag_t'(4'(item_q) + 4'h1);
      S_TRM_VIEW: tag_d = item_q[0] ? T_SLOPE : T_ZERO_OFFSET_ITEM;
      S_ALM_EDIT, S_TRM_EDIT: begin
        tag_d = T_EDIT;
        oval_d = edit_q;
      end
      S_REC_TAG: tag_d = rhi_q ? T_HITAG : T_LOTAG;
      S_REC_VAL: oval_d = rhi_q ? max_q : min_q;
      S_CLR_TAG: tag_d = T_CLTAG;
      default:   tag_d = T_VALUE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_q <= S_IDLE;
      item_q <= 2'h0;
      rhi_q <= 1'b0;
      show_q <= 5'h00;
      edit_q <= 16'sh0000;
      upper_q <= UPPER_RST;
      lower_q <= LOWER_RST;
      delay_q <= 16'sh0000;
      offset_q <= 16'sh0000;
      slope_q <= 16'sh0000;
      scalo_q <= 16'sh0000;
      ctrl_q <= 5'h00;
      min_q <= EXT_MIN_RST;
      max_q <= EXT_MAX_RST;
      oval_q <= 16'h0000;
      tag_q <= T_VALUE;
    end else if (I_CE) begin
      st_q <= st_d;
      item_q <= item_d;
      rhi_q <= rhi_d;
      show_q <= show_d;
      edit_q <= edit_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      delay_q <= delay_d;
      offset_q <= offset_d;
      slope_q <= slope_d;
      scalo_q <= scalo_d;
      ctrl_q <= ctrl_d;
      min_q <= min_d;
      max_q <= max_d;
      oval_q <= oval_d;
      tag_q <= tag_d;
    end
  end

  // corrected value and alarm delay
  logic signed [31:0] base, diff, prod;
  logic signed [15:0] disp_d, hcnt_q, hcnt_d, lcnt_q, lcnt_d;
  logic               hal_q, hal_d, lal_q, lal_d, hc, lc;

  assign hc = disp_q > upper_q;
  assign lc = disp_q < lower_q;

  always_comb begin
    base = ctrl_q[CTRL_STD_BIT] ? 32'(scalo_q) : 32'sh0;
    diff = 32'(I_MEAS) - 32'(offset_q) - base;
    prod = diff * (32'(SLOPE_ONE) + 32'(slope_q)) / 32'(SLOPE_ONE) + base;
    disp_d = 16'(prod);
    hcnt_d = !hc ? 16'sh0000 : ((stick && hcnt_q < delay_q)
             ? hcnt_q + 16'sh0001 : hcnt_q);
    lcnt_d = !lc ? 16'sh0000 : ((stick && lcnt_q < delay_q)
             ? lcnt_q + 16'sh0001 : lcnt_q);
    hal_d = (hc && hcnt_q >= delay_q) || I_SYS_ERR;
    lal_d = (lc && lcnt_q >= delay_q) || I_SYS_ERR;
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      disp_q <= 16'sh0000;
      hcnt_q <= 16'sh0000;
      lcnt_q <= 16'sh0000;
      hal_q <= 1'b0;
      lal_q <= 1'b0;
    end else if (I_CE) begin
      disp_q <= disp_d;
      hcnt_q <= hcnt_d;
      lcnt_q <= lcnt_d;
      hal_q <= hal_d;
      lal_q <= lal_d;
    end
  end

  // bus answer and read data
  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;

  always_comb begin
    ack_d = I_WB_CYC && I_WB_STB && !ack_q;
    rd_d = 32'h00000000;
    case (I_WB_ADR)
      REG_CTRL:   rd_d = {27'h0000000, ctrl_q};
      REG_SCALO:  rd_d = {16'h0000, scalo_q};
      REG_UPPER:  rd_d = {16'h0000, upper_q};
      REG_LOWER:  rd_d = {16'h0000, lower_q};
      REG_DELAY:  rd_d = {16'h0000, delay_q};
      REG_OFFSET: rd_d = {16'h0000, offset_q};
      REG_SLOPE:  rd_d = {16'h0000, slope_q};
      REG_MIN:    rd_d = {16'h0000, min_q};
      REG_MAX:    rd_d = {16'h0000, max_q};
      REG_STATUS: rd_d = {25'h0000000, lal_q, hal_q, 2'b00, st_q};
      REG_DISP:   rd_d = {16'h0000, disp_q};
      default:    rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ack_q <= 1'b0;
      rd_q <= 32'h00000000;
    end else if (I_CE) begin
      ack_q <= ack_d;
      rd_q <= rd_d;
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rd_q;
  assign O_DISP_VAL = oval_q;
  assign O_DISP_TAG = tag_q;
  assign O_HI_ALARM_N = !hal_q;
  assign O_LO_ALARM_N = !lal_q;

  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  a_hi_alarm_cause: assert property (
    I_CE && !$past(I_SYS_ERR) && !O_HI_ALARM_N |-> $past(hc) || !$past(I_CE))
    else $error("high alarm without high condition");
  a_lo_alarm_delay: assert property (
    I_CE && !$past(I_SYS_ERR) && $fell(O_LO_ALARM_N) |->
    $past(lcnt_q) >= $past(delay_q))
    else $error("low alarm before delay elapsed");
  a_delay_restart: assert property (
    I_CE && !hc |=> hcnt_q == 16'sh0000)
    else $error("delay count kept after condition dropped");
  a_sys_err_both: assert property (
    I_CE && I_SYS_ERR |=> !O_HI_ALARM_N && !O_LO_ALARM_N)
    else $error("system error did not raise both alarms");
  a_mode_clear: assert property (
    I_CE && mode_chg |=> offset_q == 16'sh0000 && slope_q == 16'sh0000)
    else $error("mode change left trim values");
  a_edit_timeout: assert property (
    I_CE && st_q == S_ALM_EDIT && idle_q > TMO_EDIT_S
    |=> st_q == S_ALM_VIEW)
    else $error("edit did not time out");
  a_menu_timeout: assert property (
    I_CE && (st_q == S_ALM_VIEW || st_q == S_TRM_VIEW)
    && idle_q > TMO_MENU_S |=> st_q == S_IDLE)
    else $error("menu did not close on idle");
  a_cancel_keeps: assert property (
    I_CE && st_q == S_ALM_EDIT && press[3] && !wr
    |=> st_q == S_ALM_VIEW && $stable(upper_q) && $stable(lower_q))
    else $error("cancel changed a parameter");
  a_item_cycle: assert property (
    I_CE && st_q == S_ALM_VIEW && press == BTN_NEXT && idle_q <= TMO_MENU_S
    |=> item_q == (($past(item_q) == 2'h2) ? 2'h0 : $past(item_q) + 2'h1))
    else $error("item did not advance");
  a_max_tracks: assert property (
    I_CE && !clr |=> max_q >= $past(disp_q) && min_q <= $past(disp_q))
    else $error("extremes missed a value");
  a_ack_pulse: assert property (
    O_WB_ACK && I_CE |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");

  c_hi_alarm: cover property (I_CE && !I_SYS_ERR && $fell(O_HI_ALARM_N));
  c_recall: cover property (st_q == S_REC_VAL);
  c_trim: cover property (st_q == S_TRM_EDIT);
  c_clear: cover property (clr);

endmodule : alm_top

// [logic/alm_pkg.sv]
// constants and types for the alarm, trim and panel menu block
package alm_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SEC_NS         = 1_000_000_000;
  localparam int FAST_PER_SEC   = 8;
  localparam int FAST_CYC       = SEC_NS / CLK_PERIOD_NS / FAST_PER_SEC;
  localparam int FAST_PERIOD_MS = 1000 / FAST_PER_SEC;
  // button and display timing, in ms and in fast ticks
  localparam int REPEAT_HOLD_MS = 1000;
  localparam int FAST_HOLD_MS   = 3000;
  localparam int COMBO_HOLD_MS  = 2000;
  localparam int TAG_SHOW_MS    = 500;
  localparam int VAL_SHOW_MS    = 2000;
  localparam logic [4:0] REPEAT_F = 5'(REPEAT_HOLD_MS / FAST_PERIOD_MS);
  localparam logic [4:0] FASTR_F  = 5'(FAST_HOLD_MS / FAST_PERIOD_MS);
  localparam logic [4:0] COMBO_F  = 5'(COMBO_HOLD_MS / FAST_PERIOD_MS);
  localparam logic [4:0] TAG_F    = 5'(TAG_SHOW_MS / FAST_PERIOD_MS);
  localparam logic [4:0] SHOW_F   = 5'(VAL_SHOW_MS / FAST_PERIOD_MS);
  // inactivity timeouts in seconds
  localparam logic [6:0] TMO_EDIT_S = 7'h0A;
  localparam logic [6:0] TMO_MENU_S = 7'h3C;
  // button masks: bit0 = button 1 ... bit4 = rear button
  localparam logic [4:0] BTN_NEXT  = 5'h01;
  localparam logic [4:0] BTN_UP    = 5'h02;
  localparam logic [4:0] BTN_DOWN  = 5'h04;
  localparam logic [4:0] BTN_ESC   = 5'h08;
  localparam logic [4:0] BTN_CLR   = 5'h06;
  localparam logic [4:0] BTN_TRIM  = 5'h14;
  // value ranges for stepping
  localparam logic signed [15:0] VAL_MIN = 16'hF831;
  localparam logic signed [15:0] VAL_MAX = 16'h270F;
  localparam logic signed [15:0] DLY_MIN = 16'h0000;
  // slope is held in hundredths of a percent
  localparam int SLOPE_ONE = 10000;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SCALO  = 8'h04;
  localparam logic [7:0] REG_UPPER  = 8'h08;
  localparam logic [7:0] REG_LOWER  = 8'h0C;
  localparam logic [7:0] REG_DELAY  = 8'h10;
  localparam logic [7:0] REG_OFFSET = 8'h14;
  localparam logic [7:0] REG_SLOPE  = 8'h18;
  localparam logic [7:0] REG_MIN    = 8'h1C;
  localparam logic [7:0] REG_MAX    = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_DISP   = 8'h28;
  // control field: [3:0] measuring mode, [4] standard signal input
  localparam int CTRL_STD_BIT = 4;
  // reset values
  localparam logic signed [15:0] UPPER_RST = 16'h03E8;
  localparam logic signed [15:0] LOWER_RST = 16'h0000;
  localparam logic signed [15:0] EXT_MIN_RST = 16'h7FFF;
  localparam logic signed [15:0] EXT_MAX_RST = 16'h8000;
  // menu states
  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_ALM_VIEW = 3'b001,
    S_ALM_EDIT = 3'b010,
    S_TRM_VIEW = 3'b011,
    S_TRM_EDIT = 3'b100,
    S_REC_TAG  = 3'b101,
    S_REC_VAL  = 3'b110,
    S_CLR_TAG  = 3'b111
  } alm_st_t;
  // display content codes
  typedef enum logic [3:0] {
    T_VALUE = 4'h0, T_UPPER = 4'h1, T_LOWER = 4'h2, T_DELAY = 4'h3,
    T_ZERO_OFFSET_ITEM  = 4'h4, T_SLOPE = 4'h5, T_LOTAG = 4'h6, T_HITAG = 4'h7,
    T_CLTAG = 4'h8, T_EDIT  = 4'h9
  } alm_tag_t;
endpackage : alm_pkg

// [tb/alm_panel.sv]
// front panel model: pushbuttons pressed and released by the bench
`timescale 1ns/100ps
module alm_panel (
  // clock
  input  wire logic       i_clk,
  // buttons towards the meter, high = pressed
  output logic      [4:0] o_btn
);
  initial o_btn = 5'h00;
  // hold a mask from this edge on
  task hold(input logic [4:0] m);
    o_btn <= m;
  endtask : hold
  // press n cycles, release, let the synchroniser settle
  task press(input logic [4:0] m, input int n = 8);
    o_btn <= m;
    repeat (n) @(posedge i_clk);
    o_btn <= 5'h00;
    repeat (10) @(posedge i_clk);
  endtask : press
endmodule : alm_panel

// [tb/alm_top_bench.sv]
// self-checking bench for the alarm, trim and panel block
`timescale 1ns/100ps
module alm_top_bench;
  import alm_pkg::*;
  logic        clk, rst_n, cyc, stb, we, ack, seg_done, sys_err, hi_n, lo_n;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [4:0]  btn;
  logic [15:0] meas, dval;
  logic [3:0]  tag;
  int          fail_count, compares;

  // 50 ns clock
  always #25 clk = ~clk;

  // one fast tick every 4 cycles keeps seconds short
  alm_top #(.FAST_CYC_P(4)) uut (
    .I_CLK           (clk),
    .I_RESET_N       (rst_n),
    .I_CE            (1'b1),
    .I_WB_CYC        (cyc),
    .I_WB_STB        (stb),
    .I_WB_WE         (we),
    .I_WB_ADR        (adr),
    .I_WB_SEL        (4'hF),
    .I_WB_DAT        (wdat),
    .O_WB_DAT        (rdat),
    .O_WB_ACK        (ack),
    .I_BTN           (btn),
    .I_SEG_TEST_DONE (seg_done),
    .I_MEAS          (meas),
    .I_SYS_ERR       (sys_err),
    .O_DISP_VAL      (dval),
    .O_DISP_TAG      (tag),
    .O_HI_ALARM_N    (hi_n),
    .O_LO_ALARM_N    (lo_n)
  );
  alm_panel u_pnl (.i_clk(clk), .o_btn(btn));

  // verdict and end of run
  task report_and_stop;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // compare seen against expected
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wc(input int n);
    repeat (n) @(posedge clk);
  endtask : wc

  // classic wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    chk(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // bounded wait for a display tag
  task wt(input logic [3:0] t, input int m);
    int n;
    n = 0;
    while (tag !== t && n < m) begin
      @(posedge clk);
      n++;
    end
    chk(tag, t);
  endtask : wt

  task pw(input logic [4:0] m, input logic [3:0] t, input int n = 8);
    u_pnl.press(m, n);
    wt(t, 20);
  endtask : pw

  // reset state and unmapped address
  task t_reset;
    chk(hi_n, 1'b1);
    chk(lo_n, 1'b1);
    rdchk(REG_UPPER, 32'h3E8);
    rdchk(REG_LOWER, 32'h0);
    wr(8'h40, 32'h1234);
    rdchk(8'h40, 32'h0);
  endtask : t_reset

  // offset and slope correction, mode change
  task t_trim;
    meas <= 16'h03F2;
    wr(REG_SCALO, 32'h64);
    wr(REG_CTRL, 32'h10);
    wr(REG_OFFSET, 32'h0A);
    wr(REG_SLOPE, 32'hC8);
    wc(4);
    chk(dval, 16'h03FA);
    rdchk(REG_DISP, 32'h3FA);
    wr(REG_CTRL, 32'h00);
    wc(4);
    chk(dval, 16'h03FC);
    wr(REG_CTRL, 32'h01);
    rdchk(REG_OFFSET, 32'h0);
    rdchk(REG_SLOPE, 32'h0);
  endtask : t_trim

  // clear, tracking and recall of extremes
  task t_ext;
    meas <= 16'h01F4;
    wc(6);
    u_pnl.hold(BTN_CLR);
    wt(T_CLTAG, 120);
    u_pnl.hold(5'h00);
    wc(10);
    rdchk(REG_MIN, 32'h1F4);
    rdchk(REG_MAX, 32'h1F4);
    meas <= 16'h02BC;
    wc(6);
    meas <= 16'h012C;
    wc(6);
    meas <= 16'h01F4;
    wc(6);
    rdchk(REG_MIN, 32'h12C);
    rdchk(REG_MAX, 32'h2BC);
    for (int i = 0; i < 2; i++) begin
      u_pnl.press(i ? BTN_UP : BTN_DOWN);
      wt(i ? T_HITAG : T_LOTAG, 20);
      wc(50);
      chk(dval, i ? 16'h02BC : 16'h012C);
      wc(60);
    end
  endtask : t_ext

  // item cycling, edit, commit, cancel, repeat, wrap
  task t_menu;
    pw(BTN_NEXT, T_UPPER);
    pw(BTN_UP, T_EDIT);
    chk(dval, 16'h03E8);
    u_pnl.press(BTN_UP);
    chk(dval, 16'h03E9);
    pw(BTN_NEXT, T_UPPER);
    rdchk(REG_UPPER, 32'h3E9);
    pw(BTN_DOWN, T_EDIT);
    u_pnl.press(BTN_DOWN);
    chk(dval, 16'h03E8);
    pw(BTN_ESC, T_UPPER);
    rdchk(REG_UPPER, 32'h3E9);
    pw(BTN_NEXT, T_LOWER);
    pw(BTN_NEXT, T_DELAY);
    pw(BTN_NEXT, T_UPPER);
    pw(BTN_UP, T_EDIT);
    u_pnl.press(BTN_UP, 24);
    chk(dval, 16'h03EA);
    u_pnl.hold(BTN_UP);
    wc(72);
    u_pnl.hold(5'h00);
    wc(10);
    chk(dval >= 16'h03EE && dval <= 16'h03F2, 1'b1);
    pw(BTN_ESC, T_UPPER);
    pw(BTN_ESC, T_VALUE);
    wr(REG_LOWER, 32'h270F);
    pw(BTN_NEXT, T_UPPER);
    pw(BTN_NEXT, T_LOWER);
    pw(BTN_UP, T_EDIT);
    u_pnl.press(BTN_UP);
    chk(dval, 16'hF831);
    u_pnl.press(BTN_DOWN);
    chk(dval, 16'h270F);
    u_pnl.press(BTN_UP);
    pw(BTN_NEXT, T_LOWER);
    rdchk(REG_LOWER, 32'hF831);
    pw(BTN_ESC, T_VALUE);
    wr(REG_LOWER, 32'h0);
  endtask : t_menu

  // idle timeouts in edit and in the menu
  task t_tmo;
    pw(BTN_NEXT, T_UPPER);
    pw(BTN_UP, T_EDIT);
    u_pnl.press(BTN_UP);
    wc(250);
    chk(tag, T_EDIT);
    wt(T_UPPER, 150);
    rdchk(REG_UPPER, 32'h3E9);
    wc(1200);
    chk(tag, T_UPPER);
    wt(T_VALUE, 500);
  endtask : t_tmo

  // trim menu opening, item toggle, signed slope
  task t_trm;
    u_pnl.press(BTN_TRIM, 90);
    chk(tag !== T_ZERO_OFFSET_ITEM, 1'b1);
    seg_done <= 1'b1;
    pw(BTN_TRIM, T_VALUE, 40);
    pw(BTN_TRIM, T_ZERO_OFFSET_ITEM, 90);
    pw(BTN_NEXT, T_SLOPE);
    pw(BTN_DOWN, T_EDIT);
    u_pnl.press(BTN_DOWN);
    chk(dval, 16'hFFFF);
    pw(BTN_NEXT, T_SLOPE);
    rdchk(REG_SLOPE, 32'hFFFF);
    pw(BTN_NEXT, T_ZERO_OFFSET_ITEM);
    pw(BTN_ESC, T_VALUE);
    wr(REG_SLOPE, 32'h0);
  endtask : t_trm

  // limit alarms with a two second delay, system error
  task t_alarm;
    wr(REG_DELAY, 32'h2);
    wr(REG_UPPER, 32'h64);
    meas <= 16'h00C8;
    wc(30);
    chk(hi_n, 1'b1);
    wc(70);
    chk(hi_n, 1'b0);
    chk(lo_n, 1'b1);
    meas <= 16'h0032;
    wc(6);
    chk(hi_n, 1'b1);
    meas <= 16'h00C8;
    wc(30);
    meas <= 16'h0032;
    wc(8);
    meas <= 16'h00C8;
    wc(28);
    chk(hi_n, 1'b1);
    meas <= 16'hFFFB;
    wc(100);
    chk(lo_n, 1'b0);
    rdchk(REG_STATUS, 32'h40);
    meas <= 16'h0032;
    wc(6);
    sys_err <= 1'b1;
    wc(2);
    chk({hi_n, lo_n}, 2'b00);
    sys_err <= 1'b0;
  endtask : t_alarm

  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {cyc, stb, we, seg_done, sys_err} = 5'h00;
    adr = 8'h00;
    wdat = 32'h0;
    meas = 16'h0000;
    fail_count = 0;
    compares = 0;
    wc(16);
    rst_n <= 1'b1;
    wc(2);
    t_reset();
    t_trim();
    t_ext();
    t_menu();
    t_tmo();
    t_trm();
    t_alarm();
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule : alm_top_bench
